// ---- qbsp_pkg.sv ----
// Summary of operation
// - Read addresses are taken on rising edges of the true clock, write addresses on rising edges of the complementary clock.
// - Each address names a burst of four data words that move in order, word 0 first.
// - Data beats move on every rising edge of both input clocks, two beats per clock cycle on each port.
// - With pll_disable high, read data starts 2.5 clock cycles after the read address is taken.
// - With pll_disable low, read data starts one clock cycle after the read address is taken.
// - Read data leaves on output-only pins and write data arrives on input-only pins.
// - The read and write paths run concurrently; only the array update waits one system cycle on a read launch.
// - The read select and the write select each enable only their own port.
// - Address, selects and write data are registered on rising edges of the input clocks.
// - Read data is launched from output registers on rising edges of the input clocks.
// - Writes are finished by internal self-timed logic without any write pulse from outside.
// - The read_valid_flag output is high during the beats that carry valid read data.
// - An echo_clock_pair is driven in step with the read data for capture by the controller.
// - Only rising edges of the two input clocks are acted on; falling edges are ignored.
// - One multiplexed address bus carries addresses for both ports.
// - A read returns the latest written data, even of a pending write, except with pll_disable low for a write addressed on the edge just before it.
package qbsp_pkg;
  localparam int DATA_W = 18;
  localparam int ADDR_W = 19;
  localparam int BURST = 4;
  localparam int FIFO_DEPTH = 4;
  localparam int LAT_MAX = 5;
  localparam logic [2:0] LAT_PLL_ON = 3'h5;
  localparam logic [2:0] LAT_PLL_OFF = 3'h2;
  localparam logic [2:0] BEAT_LAST = 3'h4;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [BURST*DATA_W-1:0] data;
  } qbsp_burst_t;

  typedef struct packed {
    logic kClk;
    logic kClkN;
    logic rdSelN;
    logic wrSelN;
    logic pllDisable;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } qbsp_pins_t;
endpackage

// ---- qbsp_port.sv ----
`timescale 1ns/1ps
`default_nettype none

module qbsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset, active low
  input wire logic inValid, // Fill side offers a word
  output logic inReady, // Room for a word
  input wire logic [WIDTH-1:0] inData, // Word in
  output logic outValid, // Word available
  input wire logic outReady, // Drain side takes the word
  output logic [WIDTH-1:0] outData // Head word
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  logic doPush;
  logic doPop;

  assign inReady = (count != (PW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == PW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == PW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (PW+1)'(doPush) - (PW+1)'(doPop);
    end
  end
endmodule // qbsp_fifo

module qbsp_port (
  input wire logic clk, // System clock, 125 MHz
  input wire logic nrst, // Async reset, active low
  input wire logic kClk, // True input clock pin
  input wire logic kClkN, // Complementary input clock pin
  input wire logic [qbsp_pkg::ADDR_W-1:0] addrIn, // Shared address bus
  input wire logic rdSelN, // Read port select, active low
  input wire logic wrSelN, // Write port select, active low
  input wire logic [qbsp_pkg::DATA_W-1:0] wrData, // Write data pins
  input wire logic pllDisable, // pll_disable pin
  output logic [qbsp_pkg::DATA_W-1:0] rdData, // Read data pins
  output logic readValidFlag, // read_valid_flag
  output logic echoClk, // echo_clock_pair, true
  output logic echoClkN // echo_clock_pair, complement
);
  import qbsp_pkg::*;

  qbsp_pins_t pins;
  qbsp_pins_t syn1;
  qbsp_pins_t syn2;
  logic kPrev;
  logic kNPrev;
  logic kRise;
  logic kNRise;
  logic halfEdge;

  logic [BURST*DATA_W-1:0] array [2**ADDR_W];

  logic [LAT_MAX-1:0] rdPipeV;
  logic [ADDR_W-1:0] rdPipeA [LAT_MAX];
  logic [2:0] lat;
  logic launch;
  logic [ADDR_W-1:0] launchAddr;
  logic [BURST*DATA_W-1:0] fetched;
  logic [BURST*DATA_W-1:0] rdBuf;
  logic [2:0] rdBeat;

  logic [2:0] wrCnt;
  logic [ADDR_W-1:0] wrAddr;
  logic [BURST*DATA_W-1:0] wrBuf;
  logic [BURST*DATA_W-1:0] next_wrBuf;
  logic [1:0] wrSlot;
  qbsp_burst_t stg;
  logic stgValid;
  logic fifoInReady;
  logic fifoOutValid;
  logic drainReady;
  qbsp_burst_t head;

  assign pins = '{kClk: kClk, kClkN: kClkN, rdSelN: rdSelN, wrSelN: wrSelN,
                  pllDisable: pllDisable, addr: addrIn, wrData: wrData};

  // Every pin crosses two flops together so beats stay aligned to their clock edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Clocks and selects reset high so a pin already high at release is no false rise
      syn1 <= '{kClk: 1'b1, kClkN: 1'b1, rdSelN: 1'b1, wrSelN: 1'b1, default: '0};
      syn2 <= '{kClk: 1'b1, kClkN: 1'b1, rdSelN: 1'b1, wrSelN: 1'b1, default: '0};
      kPrev <= 1'b1;
      kNPrev <= 1'b1;
    end else begin
      syn1 <= pins;
      syn2 <= syn1;
      kPrev <= syn2.kClk;
      kNPrev <= syn2.kClkN;
    end
  end

  // Falling edges produce no event at all
  assign kRise = syn2.kClk && !kPrev;
  assign kNRise = syn2.kClkN && !kNPrev;
  assign halfEdge = kRise || kNRise;

  // Read side: address pipeline counted in half-cycle edges
  assign lat = syn2.pllDisable ? LAT_PLL_ON : LAT_PLL_OFF;
  assign launch = halfEdge && rdPipeV[lat-3'h1];
  assign launchAddr = rdPipeA[lat-3'h1];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdPipeV <= '0;
      for (int i = 0; i < LAT_MAX; i++) begin
        rdPipeA[i] <= '0;
      end
    end else if (halfEdge) begin
      // Read address only on the true clock edge, only when selected
      rdPipeV[0] <= kRise && !syn2.rdSelN;
      rdPipeA[0] <= syn2.addr;
      for (int i = 1; i < LAT_MAX; i++) begin
        rdPipeV[i] <= rdPipeV[i-1];
        rdPipeA[i] <= rdPipeA[i-1];
      end
    end
  end

  // Newest copy wins: staged burst, then queue head, then the array.
  // Only the queue head is searched; the queue drains in a few system cycles,
  // far faster than the next read launch, so deeper entries are never live.
  always_comb begin
    fetched = array[launchAddr];
    if (fifoOutValid && head.addr == launchAddr) begin
      fetched = head.data;
    end
    if (stgValid && stg.addr == launchAddr) begin
      fetched = stg.data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdBuf <= '0;
      rdBeat <= 3'h0;
      rdData <= '0;
      readValidFlag <= 1'b0;
    end else if (halfEdge) begin
      if (launch) begin
        rdBuf <= fetched;
        rdData <= fetched[DATA_W-1:0];
        rdBeat <= 3'h1;
        readValidFlag <= 1'b1;
      end else if (rdBeat != 3'h0 && rdBeat != BEAT_LAST) begin
        rdData <= rdBuf[rdBeat[1:0]*DATA_W +: DATA_W];
        rdBeat <= rdBeat + 3'h1;
      end else begin
        rdBeat <= 3'h0;
        readValidFlag <= 1'b0;
      end
    end
  end

  // Echo pair is a registered copy of the true input clock and its inverse, same delay as rdData
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      echoClk <= 1'b0;
      echoClkN <= 1'b1;
    end else begin
      echoClk <= syn2.kClk;
      echoClkN <= !syn2.kClk;
    end
  end

  // Write side: address on the complementary edge, then four beats.
  // Slot kept at two bits so the last beat wraps to word 3, not out of range.
  assign wrSlot = wrCnt[1:0] - 2'h1;

  always_comb begin
    next_wrBuf = wrBuf;
    if (wrCnt != 3'h0) begin
      next_wrBuf[wrSlot*DATA_W +: DATA_W] = syn2.wrData;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrCnt <= 3'h0;
      wrAddr <= '0;
      wrBuf <= '0;
    end else if (halfEdge) begin
      wrBuf <= next_wrBuf;
      if (kNRise && !syn2.wrSelN) begin
        wrCnt <= 3'h1;
        wrAddr <= syn2.addr;
      end else if (wrCnt == BEAT_LAST) begin
        wrCnt <= 3'h0;
      end else if (wrCnt != 3'h0) begin
        wrCnt <= wrCnt + 3'h1;
      end
    end
  end

  // Completed burst waits here until the queue has room
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stg <= '0;
      stgValid <= 1'b0;
    end else if (halfEdge && wrCnt == BEAT_LAST) begin
      stg <= '{addr: wrAddr, data: next_wrBuf};
      stgValid <= 1'b1;
    end else if (stgValid && fifoInReady) begin
      stgValid <= 1'b0;
    end
  end

  // Array update pauses on a read launch so the fetch sees a stable word
  assign drainReady = !launch;

  qbsp_fifo #(
    .WIDTH($bits(qbsp_burst_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .inValid(stgValid),
    .inReady(fifoInReady),
    .inData(stg),
    .outValid(fifoOutValid),
    .outReady(drainReady),
    .outData(head)
  );

  // Self-timed write of one whole burst per system cycle
  always_ff @(posedge clk) begin
    if (fifoOutValid && drainReady) begin
      array[head.addr] <= head.data;
    end
  end
endmodule // qbsp_port

`default_nettype wire

// ---- qbsp_port_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module qbsp_port_asserts (
  input wire logic clk, // System clock
  input wire logic nrst, // Async reset
  input wire logic kClk, // True pin clock
  input wire logic kClkN, // Complement pin clock
  input wire logic rdSelN, // Read select
  input wire logic pllDisable, // Latency select
  input wire logic [qbsp_pkg::DATA_W-1:0] rdData, // Read beat
  input wire logic readValidFlag, // Valid beat
  input wire logic echoClk, // Echo true
  input wire logic echoClkN // Echo complement
);
  logic kP, kNP;
  logic [3:0] since, rdAge;
  logic [6:0] vRun;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Reset high so a pin already high at release is not taken for a rise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) {kP, kNP} <= 2'h3;
    else {kP, kNP} <= {kClk, kClkN};
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) since <= 4'hF;
    else if ((kClk && !kP) || (kClkN && !kNP)) since <= 4'h0;
    else if (since != 4'hF) since <= since + 4'h1;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rdAge <= 4'hF;
    else if (kClk && !kP) rdAge <= !rdSelN ? 4'h0 : rdAge + {3'h0, rdAge != 4'hF};
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) vRun <= 7'h00;
    else vRun <= !readValidFlag ? 7'h00 : vRun + {6'h00, vRun != 7'h7F};
  end
  sequence takeOff; $rose(kClk) && !rdSelN && !readValidFlag && !pllDisable; endsequence
  sequence takeOn; $rose(kClk) && !rdSelN && !readValidFlag && pllDisable; endsequence
  sequence validUp; $rose(readValidFlag); endsequence
  chk_echo_follow: assert property (
    $rose(kClk) |-> ##[3:6] $rose(echoClk)) else $error("echo clock lags input clock");
  chk_echo_pair: assert property (
    echoClkN != echoClk) else $error("echo pair not complementary");
  chk_data_on_rise: assert property (
    $changed(rdData) |-> since inside {[4'h2:4'h6]}) else $error("read data off a rise");
  chk_valid_on_rise: assert property (
    $changed(readValidFlag) |-> since inside {[4'h2:4'h6]}) else $error("valid off a rise");
  chk_valid_four: assert property (
    $fell(readValidFlag) |-> vRun >= 7'h24) else $error("valid run too short");
  chk_idle_quiet: assert property (
    rdAge >= 4'h5 |-> !readValidFlag) else $error("valid without a read");
  chk_lat_short: assert property (
    takeOff |-> ##[22:24] validUp) else $error("short latency wrong");
  chk_lat_long: assert property (
    takeOn |-> ##[52:54] validUp) else $error("long latency wrong");
endmodule // qbsp_port_asserts
bind qbsp_port qbsp_port_asserts u_chk (.clk, .nrst, .kClk, .kClkN, .rdSelN, .pllDisable,
  .rdData, .readValidFlag, .echoClk, .echoClkN);
`default_nettype wire

// ---- qbsp_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module qbsp_ctrl_model
  import qbsp_pkg::*;
(
  input wire logic clk, // System clock
  output logic kClk, // True input clock
  output logic kClkN, // Complement input clock
  output logic [qbsp_pkg::ADDR_W-1:0] addrIn, // Shared address bus
  output logic rdSelN, // Read select
  output logic wrSelN, // Write select
  output logic [qbsp_pkg::DATA_W-1:0] wrData // Write beats
);
  int cnt = 0;
  int hcnt = 0;
  int wBeat = 0;
  bit rdGap = 0;
  qbsp_burst_t cur;
  qbsp_burst_t wrQ[$];
  logic [ADDR_W-1:0] rdQ[$];
  int rdCap[$];
  initial begin
    {kClk, kClkN, rdSelN, wrSelN} = 4'h7;
    addrIn = '0;
    wrData = '0;
  end
  // Pins move mid half-period, far from any input clock rise
  always @(negedge clk) begin
    cnt = (cnt == 9) ? 0 : cnt + 1;
    if (cnt == 0) begin
      kClk = ~kClk;
      kClkN = ~kClk;
      hcnt++;
    end
    if (cnt == 5) begin
      wrData = (wBeat > 0) ? cur.data[(4-wBeat)*DATA_W +: DATA_W] : ~wrData;
      if (wBeat > 0) wBeat--;
      if (!kClk) begin
        rdSelN = !(rdQ.size() > 0 && !rdGap);
        rdGap = !rdSelN;
        addrIn = rdSelN ? ~addrIn : rdQ.pop_front();
        if (!rdSelN) rdCap.push_back(hcnt + 1);
      end else begin
        wrSelN = !(wrQ.size() > 0 && wBeat == 0);
        if (!wrSelN) begin
          cur = wrQ.pop_front();
          wBeat = 4;
        end
        addrIn = wrSelN ? ~addrIn : cur.addr;
      end
    end
  end
endmodule // qbsp_ctrl_model
`default_nettype wire

// ---- qbsp_port_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module qbsp_port_tb_top;
  import qbsp_pkg::*;
  logic clk, nrst, pllDisable, kClk, kClkN, rdSelN, wrSelN, readValidFlag, echoClk, echoClkN;
  logic [ADDR_W-1:0] addrIn;
  logic [DATA_W-1:0] wrData, rdData;
  logic seenV [4096];
  logic [DATA_W-1:0] seenD [4096];
  int numErrors = 0;
  int nCompared = 0;
  int cycles = 0;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  qbsp_ctrl_model ctl (.clk, .kClk, .kClkN, .addrIn, .rdSelN, .wrSelN, .wrData);
  qbsp_port dut (.clk, .nrst, .kClk, .kClkN, .addrIn, .rdSelN, .wrSelN, .wrData, .pllDisable,
    .rdData, .readValidFlag, .echoClk, .echoClkN);
  always @(posedge clk) begin
    if (ctl.cnt == 7) begin
      seenV[ctl.hcnt] = readValidFlag;
      seenD[ctl.hcnt] = rdData;
    end
    cycles++;
    if (cycles == 3000) begin
      numErrors++;
      wrapUp();
    end
  end
  function automatic logic [4*DATA_W-1:0] pat(input logic [7:0] s);
    pat = {s, 10'h003, s, 10'h002, s, 10'h001, s, 10'h000};
  endfunction
  task automatic wrapUp();
    if (numErrors == 0 && nCompared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [DATA_W-1:0] seen, exp);
    nCompared++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic halves(input int n);
    repeat (n * 10) @(posedge clk);
  endtask
  task automatic burst(input int c, input int lat, input logic [4*DATA_W-1:0] d, input bit tail);
    for (int i = 0; i < 4; i++) begin
      check("read word", seenD[c+lat+i], d[i*DATA_W +: DATA_W]);
      check("valid", {17'h00000, seenV[c+lat+i]}, 18'h00001);
    end
    if (tail) check("valid end", {17'h00000, seenV[c+lat+4]}, 18'h00000);
  endtask
  // Back-to-back reads overlap a write to another burst
  task automatic t_lat_off();
    ctl.wrQ.push_back('{19'h00011, pat(8'hA1)});
    ctl.wrQ.push_back('{19'h00022, pat(8'hB2)});
    halves(12);
    ctl.rdQ.push_back(19'h00011);
    ctl.rdQ.push_back(19'h00022);
    ctl.wrQ.push_back('{19'h00033, pat(8'hC3)});
    halves(16);
    burst(ctl.rdCap.pop_front(), 2, pat(8'hA1), 1'b0);
    burst(ctl.rdCap.pop_front(), 2, pat(8'hB2), 1'b1);
  endtask
  task automatic t_lat_on();
    @(negedge clk) pllDisable = 1'b1;
    @(posedge clk) ctl.rdQ.push_back(19'h00033);
    halves(16);
    burst(ctl.rdCap.pop_front(), 5, pat(8'hC3), 1'b1);
  endtask
  // Read address is taken on the edge after the last write beat, after the array update
  task automatic t_coherent();
    int n = 0;
    ctl.wrQ.push_back('{19'h00011, pat(8'hD4)});
    while (ctl.wBeat != 1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    ctl.rdQ.push_back(19'h00011);
    halves(14);
    burst(ctl.rdCap.pop_front(), 5, pat(8'hD4), 1'b1);
  endtask
  task automatic t_idle();
    halves(10);
    for (int i = 1; i <= 6; i++) check("idle valid", {17'h00000, seenV[ctl.hcnt-i]}, 18'h00000);
  endtask
  initial begin
    nrst = 1'b0;
    pllDisable = 1'b0;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    halves(2);
    t_lat_off();
    t_lat_on();
    t_coherent();
    t_idle();
    wrapUp();
  end
endmodule // qbsp_port_tb_top
`default_nettype wire
